// File: eeprom_host.sv
// Bus controller for a 64K x 8 two-wire serial EEPROM: page writes with
// acknowledge polling, current, random and sequential reads, and bus recovery.
// Assumes a pull-up on the data wire and user logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_host_defines.svh"
// Summary of operation
// - Data changes only while serial clock is low; high-clock changes mean start or stop.
// - Falling data with clock high is a start; a start precedes every command.
// - Recovery is start, nine clocks, start, then stop.
// - Every read, write and poll starts with a device word whose top nibble is the type code.
// - The last device-word bit is high for read, low for write.
// - Byte write sends two address bytes, one data byte, then stop.
// - Page write sends up to 127 further bytes before the stop.
// - Poll with start and device word; acknowledge comes once programming ends.
// - Current read: device word, one byte out, controller withholds acknowledge, stop.
// - Random read loads the address as a write, then repeated start and read word.
// - Each controller acknowledge fetches the next byte; no acknowledge plus stop ends.
module eeprom_host
    import eeprom_host_pkg::*;
#(
    parameter int LEN_W = 8,
    parameter int QUARTER_CYCLES = `QUARTER_CYCLES,
    parameter int PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire op_t op,
    input wire logic go,
    input wire logic [2:0] dev_select,
    input wire logic [15:0] word_addr,
    input wire logic [LEN_W-1:0] length,
    input wire logic write_protect_req,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic done,
    output logic error,
    output logic wp,
    output logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    localparam int TW = $clog2(PROGRAM_CYCLES + 1);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // A full page count must fit the length field.
    generate
        if (LEN_W < 8) begin : g_bad_len
            $error("LEN_W must hold a full page count");
        end
        if (PROGRAM_CYCLES < 1) begin : g_bad_prog
            $error("PROGRAM_CYCLES must be at least 1");
        end
    endgenerate

    // Device word: type code, select bits, direction.
    function automatic logic [7:0] dev_byte(input logic [2:0] sel, input logic rw);
        dev_byte = {`DEV_TYPE, sel, rw};
    endfunction

    bit_if bus ();

    state_t state;
    stage_t stage;
    op_t op_q;
    logic [2:0] sel_q;
    logic [15:0] addr_q;
    logic [LEN_W-1:0] remain;
    logic [7:0] shreg;
    logic [3:0] bitn;
    logic waiting;
    logic [TW-1:0] poll_timer;

    // ****************************************************************
    // Bit engine
    // ****************************************************************
    bit_engine #(
        .QUARTER_CYCLES(QUARTER_CYCLES)
    ) u_bit_engine (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .bus(bus),
        .sda_in(sda_in),
        .sda_oe(sda_oe),
        .scl(scl)
    );

    // ****************************************************************
    // Decode
    // ****************************************************************
    // The wire is open drain, so the only level ever driven is low.
    assign sda_out = 1'b0;
    assign busy = (state != ST_IDLE);
    assign wr_ready = (state == ST_GET);

    wire take_go = (state == ST_IDLE) && go;
    wire [LEN_W-1:0] len_eff = (length == '0) ? LEN_W'(1) : length;
    wire too_long = (op == OP_WRITE) && (length > LEN_W'(`PAGE_BYTES));
    wire last_word = (remain == LEN_W'(1));
    wire last_bit = (bitn == 4'(`BYTE_BITS - 1));
    wire last_recov = (bitn == 4'(`RECOVER_CLOCKS - 1));
    wire ack_seen = ~bus.rx_bit;
    wire poll_expired = (poll_timer >= TW'(PROGRAM_CYCLES));
    wire is_start = (state == ST_START);
    wire is_stop = (state == ST_STOP);
    // Reads withhold the acknowledge only on the last byte.
    wire rx_ack_bit = last_word;
    wire tx_data_bit = (state == ST_TX) ? shreg[7] : 1'b1;

    assign bus.req = busy && (state != ST_GET) && !waiting;
    assign bus.cmd = is_start ? CMD_START : (is_stop ? CMD_STOP : CMD_BIT);
    assign bus.tx_bit = (state == ST_RX_ACK) ? rx_ack_bit : tx_data_bit;

    // ****************************************************************
    // Engine handshake
    // ****************************************************************
    // One symbol at a time; the flag blocks a second request until done.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            waiting <= 1'b0;
        end else if (ce) begin
            if (bus.done) begin
                waiting <= 1'b0;
            end else if (bus.req) begin
                waiting <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Programming deadline
    // ****************************************************************
    // Runs only while polling, so it restarts from zero at each write stop.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            poll_timer <= '0;
        end else if (ce) begin
            if (stage != SG_POLL) begin
                poll_timer <= '0;
            end else if (!poll_expired) begin
                poll_timer <= poll_timer + TW'(1);
            end
        end
    end

    // ****************************************************************
    // Protect pin
    // ****************************************************************
    // The request comes from logic on this clock, so no synchroniser.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wp <= 1'b0;
        end else if (ce) begin
            wp <= write_protect_req;
        end
    end

    // ****************************************************************
    // Transfer sequencer
    // ****************************************************************
    // Advances on each finished symbol; the engine itself keeps bit timing.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            stage <= SG_END;
            op_q <= OP_WRITE;
            sel_q <= 3'h0;
            addr_q <= 16'h0000;
            remain <= '0;
            shreg <= 8'h00;
            bitn <= 4'h0;
            done <= 1'b0;
            error <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            rd_valid <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (take_go) begin
                        op_q <= op;
                        sel_q <= dev_select;
                        addr_q <= word_addr;
                        remain <= len_eff;
                        bitn <= 4'h0;
                        error <= too_long;
                        if (too_long) begin
                            done <= 1'b1;
                        end else begin
                            state <= ST_START;
                            unique case (op)
                                OP_RECOVER: stage <= SG_RECOV1;
                                OP_READ_CUR: stage <= SG_DEVR;
                                default: stage <= SG_DEVW;
                            endcase
                        end
                    end
                end
                ST_GET: begin
                    // Holding the clock low here stalls the bus until data comes.
                    if (wr_valid) begin
                        shreg <= wr_data;
                        state <= ST_TX;
                    end
                end
                default: begin
                    if (bus.done) begin
                        unique case (state)
                            ST_START: begin
                                bitn <= 4'h0;
                                if (stage == SG_RECOV1) begin
                                    state <= ST_RCLK;
                                end else if (stage == SG_RECOV2) begin
                                    state <= ST_STOP;
                                    stage <= SG_END;
                                end else begin
                                    shreg <= dev_byte(sel_q, stage == SG_DEVR ? `RW_READ : `RW_WRITE);
                                    state <= ST_TX;
                                end
                            end
                            ST_TX: begin
                                shreg <= {shreg[6:0], 1'b0};
                                bitn <= last_bit ? 4'h0 : bitn + 4'h1;
                                if (last_bit) begin
                                    state <= ST_TX_ACK;
                                end
                            end
                            ST_TX_ACK: begin
                                if (!ack_seen) begin
                                    // Busy programming answers nothing, so polling retries; other stages flag an error.
                                    state <= ST_STOP;
                                    if (stage != SG_POLL) begin
                                        error <= 1'b1;
                                        stage <= SG_END;
                                    end
                                end else begin
                                    unique case (stage)
                                        SG_DEVW: begin
                                            shreg <= addr_q[`ADDR_HI];
                                            stage <= SG_ADDRH;
                                            state <= ST_TX;
                                        end
                                        SG_ADDRH: begin
                                            shreg <= addr_q[`ADDR_LO];
                                            stage <= SG_ADDRL;
                                            state <= ST_TX;
                                        end
                                        SG_ADDRL: begin
                                            if (op_q == OP_WRITE) begin
                                                stage <= SG_DATA;
                                                state <= ST_GET;
                                            end else begin
                                                stage <= SG_DEVR;
                                                state <= ST_START;
                                            end
                                        end
                                        SG_DATA: begin
                                            remain <= remain - LEN_W'(1);
                                            state <= last_word ? ST_STOP : ST_GET;
                                        end
                                        SG_DEVR: state <= ST_RX;
                                        SG_POLL: begin
                                            state <= ST_STOP;
                                            stage <= SG_END;
                                        end
                                        default: begin
                                            state <= ST_STOP;
                                            stage <= SG_END;
                                        end
                                    endcase
                                end
                            end
                            ST_RX: begin
                                shreg <= {shreg[6:0], bus.rx_bit};
                                bitn <= last_bit ? 4'h0 : bitn + 4'h1;
                                if (last_bit) begin
                                    rd_data <= {shreg[6:0], bus.rx_bit};
                                    rd_valid <= 1'b1;
                                    state <= ST_RX_ACK;
                                end
                            end
                            ST_RX_ACK: begin
                                remain <= remain - LEN_W'(1);
                                if (last_word) begin
                                    state <= ST_STOP;
                                    stage <= SG_END;
                                end else begin
                                    state <= ST_RX;
                                end
                            end
                            ST_RCLK: begin
                                bitn <= last_recov ? 4'h0 : bitn + 4'h1;
                                if (last_recov) begin
                                    stage <= SG_RECOV2;
                                    state <= ST_START;
                                end
                            end
                            ST_STOP: begin
                                if (stage == SG_DATA) begin
                                    stage <= SG_POLL;
                                    state <= ST_START;
                                end else if (stage == SG_POLL && !poll_expired) begin
                                    state <= ST_START;
                                end else begin
                                    error <= error | (stage == SG_POLL);
                                    stage <= SG_END;
                                    state <= ST_IDLE;
                                    done <= 1'b1;
                                end
                            end
                            default: state <= ST_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: eeprom_host_defines.svh
// Constants for the two-wire serial EEPROM bus controller.
// Assumes a 25 MHz system clock and a single target memory per transfer.
`ifndef EEPROM_HOST_DEFINES_SVH
`define EEPROM_HOST_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 40
// One quarter of a serial bit; four quarters make one serial clock.
`define QUARTER_NS 1000
`define QUARTER_CYCLES ((`QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Longest self-timed programming cycle of the memory.
`define PROGRAM_CYCLE_TIME_MS 5
`define PROGRAM_CYCLES ((`PROGRAM_CYCLE_TIME_MS * 1000000) / `CLK_PERIOD_NS)

// ****************************************************************
// Bus words and fields
// ****************************************************************
`define BYTE_BITS 8
`define DEV_TYPE 4'hA
`define RW_READ 1'b1
`define RW_WRITE 1'b0
`define ADDR_HI 15:8
`define ADDR_LO 7:0
`define PAGE_BYTES 128
`define RECOVER_CLOCKS 9

`endif

// File: eeprom_host_pkg.sv
// Types shared by the bus controller, its bit engine and their interface.
// Assumes the defines header sits in the same folder.
`default_nettype none
package eeprom_host_pkg;
    // User operations.
    typedef enum logic [1:0] {OP_WRITE, OP_READ_CUR, OP_READ_RAND, OP_RECOVER} op_t;
    // Bit-level bus symbols.
    typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_BIT} bit_cmd_t;
    // Sequencer steps.
    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_TX, ST_TX_ACK, ST_GET, ST_RX, ST_RX_ACK, ST_STOP, ST_RCLK
    } state_t;
    // Which word of the transfer is in flight.
    typedef enum logic [3:0] {
        SG_DEVW, SG_ADDRH, SG_ADDRL, SG_DATA, SG_DEVR, SG_POLL, SG_RECOV1, SG_RECOV2, SG_END
    } stage_t;
endpackage
`default_nettype wire

// File: bit_if.sv
// Handshake between the sequencer and the bit engine.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface bit_if;
    import eeprom_host_pkg::*;
    logic req;
    bit_cmd_t cmd;
    logic tx_bit;
    logic done;
    logic rx_bit;
    modport ctrl (output req, output cmd, output tx_bit, input done, input rx_bit);
    modport engine (input req, input cmd, input tx_bit, output done, output rx_bit);
endinterface
`default_nettype wire

// File: bit_engine.sv
// Bit engine: turns start, stop and data-bit symbols into serial clock and data.
// Assumes an open-drain data wire with a pull-up and a push-pull serial clock.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_host_defines.svh"
module bit_engine
    import eeprom_host_pkg::*;
#(
    parameter int QUARTER_CYCLES = `QUARTER_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    bit_if.engine bus,
    input wire logic sda_in,
    output logic sda_oe,
    output logic scl
);
    localparam int CW = $clog2(QUARTER_CYCLES);

    // The sampling point must lie behind the two-flop synchroniser.
    generate
        if (QUARTER_CYCLES < 3) begin : g_bad_quarter
            $error("QUARTER_CYCLES must be at least 3");
        end
    endgenerate

    logic sda_meta;
    logic sda_sync;
    logic busy;
    logic [1:0] phase;
    logic [CW-1:0] cnt;
    bit_cmd_t cmd;
    logic tx;
    logic done;
    logic rx;

    // ****************************************************************
    // Pin input synchroniser
    // ****************************************************************
    // The data wire comes from outside, so it passes two flops first.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else if (ce) begin
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
        end
    end

    // ****************************************************************
    // Waveform decode
    // ****************************************************************
    // Clock is high in the middle two quarters; a stop leaves it high.
    // Data moves only in quarter 0 with the clock low, so only start and stop
    // move data in the high quarters.
    wire quarter_end = busy && (cnt == CW'(QUARTER_CYCLES - 1));
    wire mid_phase = (phase == 2'd1) || (phase == 2'd2);
    wire scl_want = (cmd == CMD_STOP) ? (phase != 2'd0) : mid_phase;
    wire start_oe = phase[1];
    wire stop_oe = ~phase[1];
    wire oe_want = (cmd == CMD_START) ? start_oe : (cmd == CMD_STOP) ? stop_oe : ~tx;
    assign bus.done = done;
    assign bus.rx_bit = rx;

    // ****************************************************************
    // Quarter sequencer
    // ****************************************************************
    // Outputs are registered, so the pins lag the phase by one cycle evenly.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy <= 1'b0;
            phase <= 2'd0;
            cnt <= '0;
            cmd <= CMD_BIT;
            tx <= 1'b1;
            done <= 1'b0;
            rx <= 1'b1;
            scl <= 1'b1;
            sda_oe <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (!busy) begin
                if (bus.req) begin
                    busy <= 1'b1;
                    cmd <= bus.cmd;
                    tx <= bus.tx_bit;
                    phase <= 2'd0;
                    cnt <= '0;
                end
            end else begin
                scl <= scl_want;
                sda_oe <= oe_want;
                if (quarter_end) begin
                    cnt <= '0;
                    phase <= phase + 2'd1;
                    if (phase == 2'd2) begin
                        rx <= sda_sync;
                    end
                    if (phase == 2'd3) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end else begin
                    cnt <= cnt + CW'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: eeprom_host_properties.sv
// Port checker for the EEPROM bus controller.
// Assumes the shared package is compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_host_defines.svh"
module eeprom_host_properties
    import eeprom_host_pkg::*;
#(parameter int LEN_W = 8) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic go,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic rd_valid,
    input wire logic busy,
    input wire logic done,
    input wire logic error,
    input wire logic scl,
    input wire logic sda_oe,
    input wire op_t op,
    input wire logic [LEN_W-1:0] length
);
    // ***
    // Taken commands; writes over a page are refused.
    // ***
    wire take = go && !busy;
    wire too_long = op == OP_WRITE && length > `PAGE_BYTES;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    done_pulse_a: assert property (done |=> !done) else $error("done held");
    bus_idle_a: assert property (!busy && !$past(busy) |-> scl && !sda_oe) else $error("bus active");
    refuse_len_a: assert property (take && too_long |=> done && error) else $error("long write");
    go_busy_a: assert property (take && !too_long |=> busy) else $error("go lost");
    start_first_a: assert property (take && !too_long |-> ##[1:20] scl && sda_oe && !$past(sda_oe))
        else $error("no start");
    rd_release_a: assert property (rd_valid |-> !sda_oe) else $error("data held");
    wr_wait_a: assert property (wr_ready |-> !scl) else $error("clock high");
    wr_take_a: assert property (wr_ready && wr_valid |=> !wr_ready) else $error("byte twice");
    cover property (rd_valid);
    cover property (wr_ready && wr_valid);
    cover property (done && error);
endmodule
bind eeprom_host eeprom_host_properties #(.LEN_W(LEN_W)) chk_u (.clk(clk), .reset_n(reset_n),
    .go(go), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_valid(rd_valid), .busy(busy),
    .done(done), .error(error), .scl(scl), .sda_oe(sda_oe), .op(op), .length(length));
`default_nettype wire

// File: eeprom_model.sv
// Behavioural two-wire serial memory facing the controller.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module eeprom_model #(parameter logic [2:0] SEL = 3'h5, parameter int BUSY_NS = 20000) (
    input wire logic scl,
    input wire logic sda,
    input wire logic wp,
    output logic dev_oe
);
    logic [7:0] mem [0:65535];
    logic [15:0] ctr;
    logic [7:0] sh, q;
    logic act, rd, ack, wrote, deaf;
    int n, idx;
    // A known fill gives every read an expected value.
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h5A;
        {dev_oe, act, rd, ack, wrote, deaf, ctr} = '0;
    end
    // Start restarts the word count, even inside a byte.
    always @(negedge sda) if (scl && !deaf) begin
        {act, rd, n, idx} = {2'b10, 64'd0};
    end
    // A stop after data makes the part deaf while it programs.
    always @(posedge sda) if (scl && !deaf) begin
        act = 0;
        deaf = wrote && !wp;
        wrote = 0;
        if (deaf) #(BUSY_NS) deaf = 0;
    end
    // Bits are taken on the rising clock; the ninth is the acknowledge.
    always @(posedge scl) if (act && !deaf) begin
        if (n < 8) sh = {sh[6:0], sda};
        else ack = !sda;
        n = (n + 1) % 9;
    end
    // Outputs change after the falling clock.
    always @(negedge scl) if (act && !deaf) begin
        dev_oe = 0;
        if (n == 8 && idx == 0) begin
            act = sh[7:1] == {4'hA, SEL};
            dev_oe = act;
            rd = sh[0];
            ack = 1;
        end else if (n == 8 && !rd) begin
            dev_oe = 1;
            if (idx == 1) ctr[15:8] = sh;
            if (idx == 2) ctr[7:0] = sh;
            if (idx > 2 && !wp) mem[ctr] = sh;
            if (idx > 2) ctr[6:0] = ctr[6:0] + 7'h01;
            wrote = wrote || idx > 2;
        end else if (rd && n == 0 && ack) begin
            q = mem[ctr];
            ctr = ctr + 16'h0001;
            dev_oe = !q[7];
        end else if (rd && n > 0 && n < 8) dev_oe = !q[7 - n];
        if (n == 8) idx++;
    end
endmodule
`default_nettype wire

// File: tb_eeprom_host.sv
// Self-checking bench: the controller drives the behavioural memory.
// Assumes all design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_eeprom_host;
    import eeprom_host_pkg::*;
    logic clk, reset_n, go, wpr, wr_valid, wr_ready, rd_valid, busy, done, error, wp, scl;
    logic sda_oe, dev_oe, sda_drv;
    logic [2:0] sel;
    logic [15:0] addr;
    logic [7:0] len, wr_data, rd_data;
    logic [7:0] got [$];
    op_t op;
    int mismatches, checks, t, k;
    // Open-drain data wire with a pull-up; the host end pulls to the level on sda_out.
    wire sda = !dev_oe && (sda_oe ? sda_drv : 1'b1);
    eeprom_host #(.QUARTER_CYCLES(3), .PROGRAM_CYCLES(2000)) dut_u (.clk(clk), .reset_n(reset_n),
        .ce(1'b1), .op(op), .go(go), .dev_select(sel), .word_addr(addr), .length(len),
        .write_protect_req(wpr), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .done(done), .error(error),
        .wp(wp), .scl(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe(sda_oe));
    eeprom_model m_u (.scl(scl), .sda(sda), .wp(wp), .dev_oe(dev_oe));
    // Clock, and a watchdog far beyond the expected run.
    initial begin
        clk = 0;
        forever #20 clk = !clk;
    end
    initial begin
        #4000000;
        mismatches++;
        complete_run;
    end
    task chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One command: write bytes count up from 8'hC0, read bytes are queued.
    task run(input op_t o, input logic [2:0] s, input logic [15:0] a, input logic [7:0] l,
        input logic e);
        @(posedge clk);
        #1 op = o;
        {sel, addr, len, go, wr_valid, k} = {s, a, l, 1'b1, o == OP_WRITE, 32'd0};
        got.delete();
        for (t = 0; t < 30000 && done !== 1'b1; t++) begin
            @(posedge clk);
            #1 go = 0;
            wr_data = 8'hC0 + k[7:0];
            @(negedge clk);
            if (rd_valid === 1'b1) got.push_back(rd_data);
            if (wr_ready === 1'b1) k++;
        end
        chk(done, 1'b1);
        chk(error, e);
    endtask
    task t_page_wrap;
        run(OP_WRITE, 3'h5, 16'h127E, 8'd3, 1'b0);
        chk(m_u.mem[16'h127F], 8'hC1);
        chk(m_u.mem[16'h1200], 8'hC2);
    endtask
    task t_rand_seq;
        run(OP_READ_RAND, 3'h5, 16'h127E, 8'd3, 1'b0);
        chk({got[0], got[2]}, 16'hC0DA);
        run(OP_READ_CUR, 3'h5, 16'h0000, 8'd1, 1'b0);
        chk(got[0], 8'hDB);
    endtask
    task t_read_wrap;
        run(OP_READ_RAND, 3'h5, 16'hFFFF, 8'd2, 1'b0);
        chk({got[0], got[1]}, 16'hA55A);
    endtask
    task t_no_match;
        run(OP_READ_CUR, 3'h2, 16'h0000, 8'd1, 1'b1);
    endtask
    task t_protect;
        @(posedge clk);
        #1 wpr = 1;
        run(OP_WRITE, 3'h5, 16'h0040, 8'd1, 1'b0);
        chk(m_u.mem[16'h0040], 8'h1A);
        run(OP_WRITE, 3'h5, 16'h0000, 8'd129, 1'b1);
        @(posedge clk);
        #1 wpr = 0;
    endtask
    task t_recover;
        run(OP_RECOVER, 3'h5, 16'h0000, 8'd0, 1'b0);
        run(OP_READ_CUR, 3'h5, 16'h0000, 8'd1, 1'b0);
        chk(got[0], 8'h1B);
    endtask
    // Reset for 20 cycles, then the scenarios in order.
    initial begin
        {reset_n, go, wpr, wr_valid, wr_data, sel, addr, len, mismatches, checks} = '0;
        op = OP_WRITE;
        repeat (20) @(posedge clk);
        #1 reset_n = 1;
        t_page_wrap;
        t_rand_seq;
        t_read_wrap;
        t_no_match;
        t_protect;
        t_recover;
        complete_run;
    end
endmodule
`default_nettype wire
